// ---- verilog/rtw_pkg.sv ----
package rtw_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] REG_CTRL_IDX = 10'h108;   // timer_control_register
   localparam logic [9:0] REG_MODE_IDX = 10'h109;   // timer_mode_register
   localparam logic [9:0] REG_IOC_IDX = 10'h10a;    // timer_io_control
   localparam logic [9:0] REG_PRESC_IDX = 10'h10c;  // prescaler_count
   localparam logic [9:0] REG_SEC_IDX = 10'h10d;    // secondary_count
   localparam logic [9:0] REG_PRIM_IDX = 10'h10e;   // primary_count
   localparam int ADDR_W = 12;
   localparam int IDX_LSB = 2;

   // control register fields
   localparam int CTRL_RUN_BIT = 0;    // count_run
   localparam int CTRL_FSTOP_BIT = 2;  // forced_stop, reads zero
   // mode register fields
   localparam int MODE_SEL_LSB = 0;
   localparam int MODE_SEL_W = 2;
   localparam int MODE_RUNNING_WRITE_TARGET_BIT = 3;   // running_write_target
   localparam int MODE_SRC_LSB = 4;
   localparam int MODE_SRC_W = 2;
   localparam logic [7:0] MODE_WMASK = 8'h3b;
   // io control fields
   localparam int IOC_OPL_BIT = 0;     // output_level_select
   localparam int IOC_OSS_BIT = 1;     // output_source_select
   localparam logic [7:0] IOC_WMASK = 8'h0f;  // b7..b4 unassigned

   // reset values
   localparam logic [7:0] RST_COUNT = 8'hff;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] FSTOP_PRIM = 8'hff;
   localparam logic [7:0] CNT_ZERO = 8'h00;
   localparam logic [7:0] CNT_ONE = 8'h01;

   // count source divider
   localparam logic [2:0] DIV_F8_LAST = 3'h7;

   typedef enum logic [1:0] {
      MODE_TIMER = 2'b00,
      MODE_WAVE = 2'b01,
      MODE_ONESHOT = 2'b10,
      MODE_WAIT = 2'b11
   } rtw_mode_t;

   typedef enum logic [1:0] {
      SRC_F1 = 2'b00,
      SRC_F8 = 2'b01,
      SRC_COMPANION = 2'b10,
      SRC_F2 = 2'b11
   } rtw_src_t;

   typedef enum logic {
      PH_PRIMARY = 1'b0,
      PH_SECONDARY = 1'b1
   } rtw_phase_t;
endpackage : rtw_pkg

// ---- verilog/rtw_timer.sv ----
module rtw_timer
   import rtw_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // neighbouring logic, same clock
   input wire logic companion_uflow_in,
   input wire logic shared_port_latch_in,
   // outputs
   output logic waveform_output_pin_out,
   output logic timer_irq_out
);

   // whole block state
   typedef struct packed {
      logic run;              // count_run
      logic [7:0] mode;       // timer_mode_register
      logic [3:0] ioc;        // timer_io_control low nibble
      logic [7:0] presc_rl;   // prescaler reload
      logic [7:0] presc_cnt;  // prescaler counter
      logic [7:0] prim_rl;    // primary reload
      logic [7:0] sec_rl;     // secondary reload
      logic [7:0] tmr_cnt;    // timer counter
      logic pend_presc;       // counter load waiting for tick
      logic pend_tmr;         // counter load waiting for prescaler underflow
      rtw_phase_t phase;      // primary or secondary period
      logic src_lat;          // latched output source select
      logic wave;             // generated waveform level
      logic pin;              // pin register
      logic irq;              // interrupt request pulse
      logic [2:0] div;        // count source divider
      logic [31:0] rdata;     // read data captured in setup
   } rtw_state_t;

   rtw_state_t q_ff;
   rtw_state_t nxt_q;

   // bus decode
   logic [9:0] idx;          // register index
   logic mapped;             // address hits a register
   logic setup;              // setup cycle
   logic wr_ev;              // write takes effect
   logic wr_ctrl;
   logic wr_mode;
   logic wr_ioc;
   logic wr_presc;
   logic wr_sec;
   logic wr_prim;
   logic start_ev;           // count start
   logic fstop_ev;           // forced stop
   logic stop_ev;            // count_run written zero
   rtw_mode_t mode_sel;
   rtw_src_t src_sel;
   logic tick;               // count source tick
   logic presc_uf;           // prescaler underflow pulse
   logic tmr_uf;             // timer underflow pulse
   logic wave_mode;

   assign idx = paddr_in[ADDR_W-1:IDX_LSB];
   assign mapped = (idx == REG_CTRL_IDX) || (idx == REG_MODE_IDX) || (idx == REG_IOC_IDX)
                   || (idx == REG_PRESC_IDX) || (idx == REG_SEC_IDX) || (idx == REG_PRIM_IDX);
   assign setup = psel_in && !penable_in;
   assign wr_ev = psel_in && penable_in && pwrite_in && mapped;
   assign wr_ctrl = wr_ev && (idx == REG_CTRL_IDX);
   assign wr_mode = wr_ev && (idx == REG_MODE_IDX);
   assign wr_ioc = wr_ev && (idx == REG_IOC_IDX);
   assign wr_presc = wr_ev && (idx == REG_PRESC_IDX);
   assign wr_sec = wr_ev && (idx == REG_SEC_IDX);
   assign wr_prim = wr_ev && (idx == REG_PRIM_IDX);
   assign fstop_ev = wr_ctrl && pwdata_in[CTRL_FSTOP_BIT];
   assign start_ev = wr_ctrl && pwdata_in[CTRL_RUN_BIT] && !q_ff.run && !fstop_ev;
   assign stop_ev = wr_ctrl && !pwdata_in[CTRL_RUN_BIT];
   assign mode_sel = rtw_mode_t'(q_ff.mode[MODE_SEL_LSB +: MODE_SEL_W]);
   assign src_sel = rtw_src_t'(q_ff.mode[MODE_SRC_LSB +: MODE_SRC_W]);
   assign wave_mode = (mode_sel == MODE_WAVE);

   // zero wait state slave; unmapped addresses answer with an error
   assign pready_out = 1'b1;
   assign pslverr_out = psel_in && penable_in && !mapped;
   assign prdata_out = q_ff.rdata;
   assign waveform_output_pin_out = q_ff.pin;
   assign timer_irq_out = q_ff.irq;

   // count source select, divider runs freely so f2/f8 phase is not tied to start
   always_comb begin
      unique case (src_sel)
         SRC_F1: tick = q_ff.run;
         SRC_F2: tick = q_ff.run && q_ff.div[0];
         SRC_F8: tick = q_ff.run && (q_ff.div == DIV_F8_LAST);
         SRC_COMPANION: tick = q_ff.run && companion_uflow_in;
      endcase
   end

   // underflow is a decrement out of zero
   assign presc_uf = tick && (q_ff.presc_cnt == CNT_ZERO) && !q_ff.pend_presc;
   assign tmr_uf = presc_uf && (q_ff.tmr_cnt == CNT_ZERO) && !q_ff.pend_tmr;

   // next state
   always_comb begin
      nxt_q = q_ff;
      nxt_q.irq = 1'b0;
      nxt_q.div = q_ff.div + 3'h1;

      // prescaler, reload copied only on a tick
      if (tick) begin
         if (q_ff.pend_presc || presc_uf) begin
            nxt_q.presc_cnt = q_ff.presc_rl;
            nxt_q.pend_presc = 1'b0;
         end else begin
            nxt_q.presc_cnt = q_ff.presc_cnt - CNT_ONE;
         end
      end

      // timer, reload copied only on prescaler underflow
      if (presc_uf) begin
         if (q_ff.pend_tmr) begin
            nxt_q.tmr_cnt = q_ff.prim_rl;
            nxt_q.pend_tmr = 1'b0;
         end else if (tmr_uf) begin
            if (wave_mode && (q_ff.phase == PH_PRIMARY)) begin
               // primary ended: count secondary next
               nxt_q.tmr_cnt = q_ff.sec_rl;
               nxt_q.phase = PH_SECONDARY;
               nxt_q.wave = q_ff.ioc[IOC_OPL_BIT];
            end else begin
               // secondary ended, or any mode other than waveform
               nxt_q.tmr_cnt = q_ff.prim_rl;
               nxt_q.phase = PH_PRIMARY;
               nxt_q.wave = !q_ff.ioc[IOC_OPL_BIT];
               nxt_q.irq = 1'b1;
               nxt_q.src_lat = q_ff.ioc[IOC_OSS_BIT];
            end
         end else begin
            nxt_q.tmr_cnt = q_ff.tmr_cnt - CNT_ONE;
         end
      end

      // register writes
      if (wr_mode) begin
         nxt_q.mode = pwdata_in[7:0] & MODE_WMASK;
      end
      if (wr_ioc) begin
         // software keeps these zero in timer mode; hardware stores as written
         nxt_q.ioc = pwdata_in[3:0];
      end
      if (wr_presc) begin
         nxt_q.presc_rl = pwdata_in[7:0];
         if (!q_ff.run) begin
            nxt_q.presc_cnt = pwdata_in[7:0];
         end else if (!wave_mode && !q_ff.mode[MODE_RUNNING_WRITE_TARGET_BIT]) begin
            // counter follows at the next tick, not now
            nxt_q.pend_presc = 1'b1;
         end
      end
      if (wr_sec) begin
         nxt_q.sec_rl = pwdata_in[7:0];
      end
      if (wr_prim) begin
         nxt_q.prim_rl = pwdata_in[7:0];
         if (!q_ff.run) begin
            nxt_q.tmr_cnt = pwdata_in[7:0];
         end else if (!wave_mode && !q_ff.mode[MODE_RUNNING_WRITE_TARGET_BIT]) begin
            nxt_q.pend_tmr = 1'b1;
         end
      end

      // start, stop and forced stop
      if (start_ev) begin
         nxt_q.run = 1'b1;
         nxt_q.phase = PH_PRIMARY;
         nxt_q.tmr_cnt = q_ff.prim_rl;
         nxt_q.presc_cnt = q_ff.presc_rl;
         nxt_q.pend_presc = 1'b0;
         nxt_q.pend_tmr = 1'b0;
         nxt_q.wave = !q_ff.ioc[IOC_OPL_BIT];
         nxt_q.src_lat = q_ff.ioc[IOC_OSS_BIT];
      end else if (stop_ev || fstop_ev) begin
         nxt_q.run = 1'b0;
         nxt_q.phase = PH_PRIMARY;
         nxt_q.pend_presc = 1'b0;
         nxt_q.pend_tmr = 1'b0;
      end
      if (fstop_ev) begin
         nxt_q.prim_rl = FSTOP_PRIM;
         nxt_q.tmr_cnt = FSTOP_PRIM;
      end
      if (!nxt_q.run) begin
         // stopped level equals the secondary level
         nxt_q.wave = nxt_q.ioc[IOC_OPL_BIT];
      end

      // pin: waveform only in waveform mode with the latched source select clear, else the port latch
      if (wave_mode && !nxt_q.src_lat) begin
         nxt_q.pin = nxt_q.wave;
      end else begin
         nxt_q.pin = shared_port_latch_in;
      end

      // read data captured in setup so prdata comes from a flop
      if (setup) begin
         nxt_q.rdata = '0;
         unique case (idx)
            REG_CTRL_IDX: nxt_q.rdata[CTRL_RUN_BIT] = q_ff.run;
            REG_MODE_IDX: nxt_q.rdata[7:0] = q_ff.mode;
            REG_IOC_IDX: nxt_q.rdata[3:0] = q_ff.ioc;
            REG_PRESC_IDX: nxt_q.rdata[7:0] = q_ff.presc_cnt;
            REG_SEC_IDX: nxt_q.rdata[7:0] = q_ff.sec_rl;
            REG_PRIM_IDX: nxt_q.rdata[7:0] = q_ff.tmr_cnt;
            default: nxt_q.rdata = '0;
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         q_ff <= '{run: 1'b0, mode: RST_ZERO, ioc: 4'h0, presc_rl: RST_COUNT,
                   presc_cnt: RST_COUNT, prim_rl: RST_COUNT, sec_rl: RST_COUNT,
                   tmr_cnt: RST_COUNT, pend_presc: 1'b0, pend_tmr: 1'b0,
                   phase: PH_PRIMARY, src_lat: 1'b0, wave: 1'b0, pin: 1'b0,
                   irq: 1'b0, div: 3'h0, rdata: 32'h0};
      end else begin
         q_ff <= nxt_q;
      end
   end

   // checks
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (sys_rst_in);

   sequence s_start;
      start_ev;
   endsequence

   sequence s_sec_uf;
      wave_mode && tmr_uf && (q_ff.phase == PH_SECONDARY);
   endsequence

   sequence s_prim_uf;
      wave_mode && tmr_uf && (q_ff.phase == PH_PRIMARY);
   endsequence

   a_ioc_read_zero: assert property (
      psel_in && penable_in && !pwrite_in && (idx == REG_IOC_IDX) |-> prdata_out[7:4] == 4'h0)
      else $error("io control upper bits not zero");

   a_presc_sync_load: assert property (
      q_ff.run && !tick && !fstop_ev && !start_ev |=> $stable(q_ff.presc_cnt))
      else $error("prescaler counter moved without tick");

   a_tmr_sync_load: assert property (
      q_ff.run && !presc_uf && !fstop_ev && !start_ev |=> $stable(q_ff.tmr_cnt))
      else $error("timer counter moved without prescaler underflow");

   a_write_no_jump: assert property (
      wr_prim && q_ff.run && !presc_uf && !fstop_ev |=> q_ff.tmr_cnt == $past(q_ff.tmr_cnt))
      else $error("running write changed counter at once");

   a_wave_invert: assert property (
      wave_mode && tmr_uf && !wr_ctrl && !wr_ioc |=> q_ff.wave != $past(q_ff.wave))
      else $error("waveform did not invert on underflow");

   a_first_primary: assert property (
      s_start |=> q_ff.run && (q_ff.phase == PH_PRIMARY) && (q_ff.tmr_cnt == $past(q_ff.prim_rl)))
      else $error("start did not begin primary period");

   a_irq_after_sec: assert property (
      s_sec_uf and !wr_ctrl |=> timer_irq_out ##1 !timer_irq_out)
      else $error("irq missing after secondary underflow");

   a_irq_cause: assert property (
      timer_irq_out |-> $past(tmr_uf))
      else $error("irq without underflow");

   a_stop_run: assert property (
      stop_ev || fstop_ev |=> !q_ff.run)
      else $error("stop write did not stop counting");

   a_fstop_ff: assert property (
      fstop_ev |=> (q_ff.prim_rl == FSTOP_PRIM) && (q_ff.tmr_cnt == FSTOP_PRIM))
      else $error("forced stop did not set primary to ff");

   a_stopped_level: assert property (
      !q_ff.run && wave_mode && !q_ff.src_lat && $stable(q_ff.ioc) [*2]
      |-> waveform_output_pin_out == q_ff.ioc[IOC_OPL_BIT])
      else $error("stopped pin level wrong");

   a_port_source: assert property (
      wave_mode && q_ff.src_lat && $stable(q_ff.src_lat)
      |-> waveform_output_pin_out == $past(shared_port_latch_in))
      else $error("pin does not show port latch");

   // prescaler underflow only out of zero, then reload from the prescaler reload
   a_uf_pulse: assert property (
      presc_uf |-> tick && (q_ff.presc_cnt == CNT_ZERO)
      ##1 (q_ff.presc_cnt == $past(q_ff.presc_rl)))
      else $error("underflow not from zero");

   // alternation: primary end loads secondary, secondary end loads primary
   a_sec_reload: assert property (
      s_prim_uf and !wr_ctrl
      |=> (q_ff.tmr_cnt == $past(q_ff.sec_rl)) && (q_ff.phase == PH_SECONDARY))
      else $error("secondary period not loaded");

   a_prim_reload: assert property (
      s_sec_uf and !wr_ctrl
      |=> (q_ff.tmr_cnt == $past(q_ff.prim_rl)) && (q_ff.phase == PH_PRIMARY))
      else $error("primary period not loaded");

   // level checks use the level select as it stood at the underflow
   a_sec_level: assert property (
      s_prim_uf and !wr_ctrl |=> q_ff.wave == $past(q_ff.ioc[IOC_OPL_BIT]))
      else $error("secondary level wrong");

   a_prim_level: assert property (
      s_sec_uf and !wr_ctrl |=> q_ff.wave != $past(q_ff.ioc[IOC_OPL_BIT]))
      else $error("primary level wrong");

   // pin register follows the generated level when the waveform is routed out
   a_pin_wave: assert property (
      $past(wave_mode) && !q_ff.src_lat |-> waveform_output_pin_out == q_ff.wave)
      else $error("pin does not show waveform");

   // output source may only move at start or together with the interrupt
   a_src_hold: assert property (
      !$stable(q_ff.src_lat) |-> $past(start_ev) || timer_irq_out)
      else $error("source select latched at wrong time");

   // stopped writes land in the counters at once
   a_presc_wr_stop: assert property (
      wr_presc && !q_ff.run |=> q_ff.presc_cnt == $past(pwdata_in[7:0]))
      else $error("stopped prescaler write not loaded");

   a_prim_wr_stop: assert property (
      wr_prim && !q_ff.run |=> q_ff.tmr_cnt == $past(pwdata_in[7:0]))
      else $error("stopped primary write not loaded");

   // no count source reaches the counters while stopped
   a_idle_no_tick: assert property (
      !q_ff.run |-> !tick && !presc_uf)
      else $error("tick while stopped");

endmodule : rtw_timer

// ---- tb/rtw_pin_probe.sv ----
module rtw_pin_probe (
   // clock and watched pin
   input wire logic clk_in,
   input wire logic pin_in,
   // last completed high and low run lengths, in clocks
   output logic [15:0] hi_len_out,
   output logic [15:0] lo_len_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic prev_ff = 1'b0; // level seen at the previous edge
   logic [15:0] run_ff = 16'h0000; // clocks spent at that level
   // behaves like a scope on the pin: no handshake, only levels
   always_ff @(posedge clk_in) begin
      prev_ff <= pin_in;
      if (pin_in !== prev_ff) begin
         run_ff <= 16'h0001;
         if (prev_ff === 1'b1) hi_len_out <= run_ff;
         else lo_len_out <= run_ff;
      end else begin
         run_ff <= run_ff + 16'h0001;
      end
   end
endmodule : rtw_pin_probe

// ---- tb/reload_timer_waveform_gen_tb.sv ----
module reload_timer_waveform_gen_tb
   import rtw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_in = 1'b0, sys_rst_in = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic pready, pslverr, rerr, comp = 1'b0, latch = 1'b0, pin, irq, prev_pin = 1'b0;
   logic wave_on = 1'b0, opl;
   logic [15:0] hi_len, lo_len;
   logic [31:0] seed = 32'hc1b86216, r1;
   logic [1:0] n, m, p, cdiv = 2'h0;
   logic [3:0] fac; // clocks between ticks for the current source
   int failures = 0, cmp_count = 0, cyc = 0;
   int irq_n = 0, irq_mark = 0; // irq pulses seen while the waveform runs
   rtw_src_t srcs [4] = '{SRC_F1, SRC_F2, SRC_F8, SRC_COMPANION};
   logic [3:0] facs [4] = '{4'h1, 4'h2, 4'h8, 4'h4}; // ticks are this many clocks apart
   rtw_timer uut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .companion_uflow_in(comp), .shared_port_latch_in(latch),
      .waveform_output_pin_out(pin), .timer_irq_out(irq));
   rtw_pin_probe probe (.clk_in(clk_sys_in), .pin_in(pin), .hi_len_out(hi_len),
      .lo_len_out(lo_len));
   // 200 MHz system clock
   initial begin
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // expected period length in clocks
   function automatic logic [15:0] plen(input logic [1:0] a, input logic [1:0] b,
      input logic [3:0] f);
      return (16'(a) + 16'h1) * (16'(b) + 16'h1) * 16'(f);
   endfunction : plen
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic finish_test();
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test
   // one apb transfer; waits on pready, takes data at that same edge
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
      int k;
      @(posedge clk_sys_in);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk_sys_in);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_sys_in);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) failures++;
   endtask : apb
   // companion timer stand-in: one pulse every fourth clock
   always @(posedge clk_sys_in) begin
      cdiv <= cdiv + 2'h1;
      comp <= (cdiv == 2'h3);
   end
   // irq must coincide with the pin entering the primary level
   always @(posedge clk_sys_in) begin
      prev_pin <= pin;
      if (wave_on && irq === 1'b1) begin
         irq_n++;
         check({pin ^ prev_pin, pin}, {1'b1, ~opl}, "irq edge");
      end
   end
   // hang guard, well above the planned run
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 30000) begin
         failures++;
         finish_test();
      end
   end
   initial begin
      repeat (8) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      apb(0, REG_PRESC_IDX, 8'h00);
      check(rdat, 32'hff, "presc reset");
      check(rerr, 1'b0, "mapped no error");
      apb(0, REG_PRIM_IDX, 8'h00);
      check(rdat, 32'hff, "prim reset");
      apb(1, REG_IOC_IDX, 8'hfc);
      apb(0, REG_IOC_IDX, 8'h00);
      check(rdat, 32'h0c, "ioc readback");
      apb(0, 10'h3ff, 8'h00);
      check(rerr, 1'b1, "unmapped error");
      check(rdat, 32'h0, "unmapped data");
      // waveform mode across every count source, random periods
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         {opl, p, m, n} = seed[6:0];
         fac = facs[i % 4];
         apb(1, REG_CTRL_IDX, 8'h00);
         apb(1, REG_PRESC_IDX, {6'h0, n});
         apb(1, REG_SEC_IDX, {6'h0, p});
         apb(1, REG_PRIM_IDX, {6'h0, m});
         apb(1, REG_MODE_IDX, {2'b00, srcs[i % 4], 4'b0001});
         apb(1, REG_IOC_IDX, {7'h0, opl});
         apb(1, REG_CTRL_IDX, 8'h01);
         wave_on = 1'b1;
         irq_mark = irq_n;
         repeat (700) @(posedge clk_sys_in);
         check(opl ? lo_len : hi_len, plen(n, m, fac), "primary");
         check(opl ? hi_len : lo_len, plen(n, p, fac), "secondary");
         m = seed[9:8];
         apb(1, REG_PRIM_IDX, {6'h0, m}); // running write, reload only
         repeat (700) @(posedge clk_sys_in);
         check(opl ? lo_len : hi_len, plen(n, m, fac), "new primary");
         check(irq_n > irq_mark, 1'b1, "irq seen");
         wave_on = 1'b0;
      end
      apb(1, REG_CTRL_IDX, 8'h04);
      apb(0, REG_PRIM_IDX, 8'h00);
      check(rdat, 32'hff, "fstop prim");
      apb(0, REG_CTRL_IDX, 8'h00);
      check(rdat[0], 1'b0, "fstop run");
      check(pin, opl, "stop level");
      // timer mode on f8, io bits kept at zero
      apb(1, REG_IOC_IDX, 8'h00);
      apb(1, REG_MODE_IDX, 8'h10);
      apb(1, REG_PRESC_IDX, 8'h07);
      apb(1, REG_PRIM_IDX, 8'hff);
      apb(1, REG_CTRL_IDX, 8'h01);
      apb(0, REG_PRIM_IDX, 8'h00);
      r1 = rdat;
      repeat (200) @(posedge clk_sys_in);
      apb(0, REG_PRIM_IDX, 8'h00);
      check(rdat < r1, 1'b1, "live count");
      apb(1, REG_MODE_IDX, 8'h18);
      apb(1, REG_PRIM_IDX, 8'h10);
      apb(0, REG_PRIM_IDX, 8'h00);
      check(rdat == 32'h10, 1'b0, "reload only");
      apb(1, REG_MODE_IDX, 8'h10);
      apb(1, REG_PRIM_IDX, 8'h20);
      apb(0, REG_PRIM_IDX, 8'h00);
      check(rdat == 32'h20, 1'b0, "no direct load");
      repeat (150) @(posedge clk_sys_in);
      apb(0, REG_PRIM_IDX, 8'h00);
      check(rdat <= 32'h20 && rdat >= 32'h1d, 1'b1, "synced load");
      // port latch routed to the pin
      apb(1, REG_CTRL_IDX, 8'h00);
      apb(1, REG_IOC_IDX, 8'h02);
      apb(1, REG_MODE_IDX, 8'h01);
      apb(1, REG_CTRL_IDX, 8'h01);
      for (int j = 0; j < 4; j++) begin
         seed = lfsr(seed);
         latch <= seed[0];
         repeat (4) @(posedge clk_sys_in);
         check(pin, latch, "latch pin");
      end
      finish_test();
   end
endmodule : reload_timer_waveform_gen_tb
